// [rtl/srb_regs.svh]
// Offsets, field positions, reset values and timing counts of the
// self-refreshing DDR pseudo-static memory device.
// Assumes a 10 ns core clock and a host that owns the link clock and select.
//
// Behaviour
// - An access opening a row buffers it and writes it back, refreshing it.
// - Self-refresh runs only between host accesses; pending refresh waits for the end. A refresh already running when a frame opens still finishes.
// - Access starting before refresh completes sees strobe high during command-address.
// - Single-row refreshes are spread evenly over the array interval.
// - All 8192 rows refreshed within 64 ms (85 C) or 16 ms (105 C).
// - Interval field: 10b base, 11b 1.5x, 00b 2x, 01b 4x the base period.
// - Maximum select-low time is half of array interval divided by row count.
// - Read latency: data lines released, strobe held low; read data drives both.
// - Write latency: data lines and strobe both released for turnaround.
// - Device always drives strobe in command-address; may release it in zero-latency write. The code leaves it undriven in a frame begun in deep sleep.
// - Zero-latency writes mask nothing; every byte is stored.
// - Register writes have zero latency, captured right after command-address.
// - Fixed-latency bit, set at reset, forces strobe high in every command-address. The code leaves strobe undriven in a frame begun in deep sleep.
`ifndef SRB_REGS_SVH
`define SRB_REGS_SVH

// Register selects carried in the command-address word
`define SRB_REG_MAIN_CONFIG      1'h0
`define SRB_REG_REFRESH_CONFIG   1'h1

// Field positions
`define SRB_MAIN_AWAKE_BIT       15
`define SRB_MAIN_FIXED_BIT       3
`define SRB_CA_READ_BIT          47
`define SRB_CA_REGSP_BIT         46
`define SRB_CA_REGSEL_BIT        0

// Reset values
`define SRB_MAIN_AWAKE_RESET     1'h1
`define SRB_MAIN_FIXED_RESET     1'h1
`define SRB_RCFG_IVL_RESET       2'h2

// Timing
`define SRB_CLK_PERIOD_NS        10
`define SRB_BASE_INTERVAL_NS     4000
`define SRB_BASE_INTERVAL_CYC    (`SRB_BASE_INTERVAL_NS / `SRB_CLK_PERIOD_NS)
`define SRB_ARRAY_ROWS           8192
`define SRB_ARRAY_INTERVAL_NS    64000000
`define SRB_MAX_SEL_LOW_NS       (`SRB_ARRAY_INTERVAL_NS / `SRB_ARRAY_ROWS / 2)
`define SRB_REFRESH_OP_CYC       6
`define SRB_CA_EDGES             6
`define SRB_LATENCY_EDGES        12

`endif

// [rtl/srb_pkg.sv]
// Types shared by the self-refreshing memory device.
// Assumes nothing beyond a SystemVerilog compiler.
package srb_pkg;
   typedef logic [7:0]  srb_byte_t;
   typedef logic [15:0] srb_word_t;

   // Link phases, Gray along command-address, latency, data
   typedef enum logic [1:0] {
      LS_CA     = 2'h0,
      LS_LAT    = 2'h1,
      LS_DATA   = 2'h3,
      LS_IGNORE = 2'h2
   } srb_link_state_t;

   // Distributed refresh interval codes
   typedef enum logic [1:0] {
      IVL_X2   = 2'h0,
      IVL_X4   = 2'h1,
      IVL_X1   = 2'h2,
      IVL_X1_5 = 2'h3
   } srb_interval_t;
endpackage

// [rtl/srb_device.sv]
// Device end of the DDR memory link: refresh scheduler, config registers,
// link phase sequencer and a byte array.
// Assumes the host drives link_clk only while cs_n is low.
`timescale 1ns/1ns
`include "srb_regs.svh"
module srb_device #(
   parameter int ADDR_W        = 10,
   parameter int ROWS          = `SRB_ARRAY_ROWS,
   parameter int BASE_CYC      = `SRB_BASE_INTERVAL_CYC,
   parameter int REFRESH_CYC   = `SRB_REFRESH_OP_CYC,
   parameter int LATENCY_EDGES = `SRB_LATENCY_EDGES
) (
   input  logic                    ref_clk,
   input  logic                    srst,
   input  logic                    link_clk,
   input  logic                    cs_n,
   input  srb_pkg::srb_byte_t      byte_lines_in,
   output srb_pkg::srb_byte_t      byte_lines_out,
   output logic                    byte_lines_oe,
   input  logic                    read_write_strobe_in,
   output logic                    read_write_strobe_out,
   output logic                    read_write_strobe_oe,
   output logic [$clog2(ROWS)-1:0] refresh_row
);
   import srb_pkg::*;

   localparam int ROW_W           = $clog2(ROWS);
   localparam int DEPTH           = 1 << ADDR_W;
   localparam int MAX_SEL_LOW_CYC = `SRB_MAX_SEL_LOW_NS / `SRB_CLK_PERIOD_NS;

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr
      $error("ADDR_W out of range");
   end
   if (BASE_CYC < 1 || BASE_CYC > 16383) begin : g_bad_base
      $error("BASE_CYC out of range");
   end
   if (REFRESH_CYC < 1 || REFRESH_CYC > 255 || REFRESH_CYC >= MAX_SEL_LOW_CYC) begin : g_bad_op
      $error("REFRESH_CYC out of range");
   end
   if (LATENCY_EDGES < 1 || LATENCY_EDGES > 16) begin : g_bad_lat
      $error("LATENCY_EDGES out of range");
   end
   if (longint'(ROWS) * BASE_CYC * `SRB_CLK_PERIOD_NS > `SRB_ARRAY_INTERVAL_NS) begin : g_bad_rows
      $error("rows cannot all be refreshed within the array interval");
   end

   // Slot period in core cycles for an interval code
   function automatic srb_word_t srb_period(input srb_interval_t sel, input srb_word_t base);
      case (sel)
         IVL_X1:   return base;
         IVL_X1_5: return base + (base >> 1);
         IVL_X2:   return base << 1;
         default:  return base << 2;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // Core domain: input synchronisers
   // -----------------------------------------------------------------
   logic          cs_low_s1_reg;
   logic          cs_low_s2_reg;
   logic          cs_low_d_reg;
   logic          wr_tgl_s1_reg;
   logic          wr_tgl_s2_reg;
   logic          wr_tgl_d_reg;
   logic          host_active;
   logic          frame_start;
   logic          frame_end;
   logic          wr_event;
   // Link-side register write holding flops
   logic          reg_wtgl_reg;
   srb_word_t     reg_wdata_reg;
   logic          reg_wsel_reg;
   srb_byte_t     reg_hi_reg;

   // Select pin and write toggle, two flops then edge detect
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cs_low_s1_reg <= 1'b0;
         cs_low_s2_reg <= 1'b0;
         cs_low_d_reg  <= 1'b0;
         wr_tgl_s1_reg <= 1'b0;
         wr_tgl_s2_reg <= 1'b0;
         wr_tgl_d_reg  <= 1'b0;
      end else begin
         cs_low_s1_reg <= ~cs_n;
         cs_low_s2_reg <= cs_low_s1_reg;
         cs_low_d_reg  <= cs_low_s2_reg;
         wr_tgl_s1_reg <= reg_wtgl_reg;
         wr_tgl_s2_reg <= wr_tgl_s1_reg;
         wr_tgl_d_reg  <= wr_tgl_s2_reg;
      end
   end

   assign host_active = cs_low_s2_reg;
   assign frame_start = cs_low_s2_reg & ~cs_low_d_reg;
   assign frame_end   = cs_low_d_reg & ~cs_low_s2_reg;
   assign wr_event    = wr_tgl_s2_reg ^ wr_tgl_d_reg;

   // -----------------------------------------------------------------
   // Core domain: configuration registers
   // -----------------------------------------------------------------
   logic          awake_reg;
   logic          fixed_reg;
   srb_interval_t ivl_reg;
   logic          asleep_frame_reg;
   srb_word_t     main_word;
   srb_word_t     rcfg_word;

   // Register writes; a frame begun in deep sleep wakes the device
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         awake_reg <= `SRB_MAIN_AWAKE_RESET;
         fixed_reg <= `SRB_MAIN_FIXED_RESET;
         ivl_reg   <= srb_interval_t'(`SRB_RCFG_IVL_RESET);
      end else if (wr_event) begin
         if (reg_wsel_reg == `SRB_REG_MAIN_CONFIG) begin
            awake_reg <= reg_wdata_reg[`SRB_MAIN_AWAKE_BIT];
            fixed_reg <= reg_wdata_reg[`SRB_MAIN_FIXED_BIT];
         end else begin
            ivl_reg <= srb_interval_t'(reg_wdata_reg[1:0]);
         end
      end else if (frame_end && asleep_frame_reg) begin
         awake_reg <= 1'b1;
      end
   end

   // Marks a frame that began while asleep (dummy wake frame)
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         asleep_frame_reg <= 1'b0;
      end else if (frame_start) begin
         asleep_frame_reg <= ~awake_reg;
      end else if (frame_end) begin
         asleep_frame_reg <= 1'b0;
      end
   end

   // Read-back words; reserved bits read zero
   assign main_word = (srb_word_t'(awake_reg) << `SRB_MAIN_AWAKE_BIT) |
                      (srb_word_t'(fixed_reg) << `SRB_MAIN_FIXED_BIT);
   assign rcfg_word = {14'h0000, ivl_reg};

   // -----------------------------------------------------------------
   // Core domain: distributed refresh scheduler
   // -----------------------------------------------------------------
   srb_word_t        period_cyc;
   srb_word_t        timer_reg;
   logic             slot_tick;
   logic             pending_reg;
   logic [7:0]       busy_cnt_reg;
   logic             refresh_start;
   logic [ROW_W-1:0] row_reg;
   logic             refresh_need_reg;

   assign period_cyc    = srb_period(ivl_reg, srb_word_t'(BASE_CYC));
   assign slot_tick     = awake_reg && (timer_reg >= period_cyc - 16'h0001);
   // Start only between host accesses, one row per slot
   assign refresh_start = pending_reg && !host_active && (busy_cnt_reg == 8'h00);

   // Slot timer; deep sleep stops new refresh starts, a running one finishes
   always_ff @(posedge ref_clk) begin
      if (srst || !awake_reg || slot_tick) begin
         timer_reg <= 16'h0000;
      end else begin
         timer_reg <= timer_reg + 16'h0001;
      end
   end

   // Pending request; a new slot wins over the start that clears it
   always_ff @(posedge ref_clk) begin
      if (srst || !awake_reg) begin
         pending_reg <= 1'b0;
      end else if (slot_tick) begin
         pending_reg <= 1'b1;
      end else if (refresh_start) begin
         pending_reg <= 1'b0;
      end
   end

   // Single-row refresh in progress; finishes even if a host frame opens
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         busy_cnt_reg <= 8'h00;
      end else if (refresh_start) begin
         busy_cnt_reg <= 8'(REFRESH_CYC);
      end else if (busy_cnt_reg != 8'h00) begin
         busy_cnt_reg <= busy_cnt_reg - 8'h01;
      end
   end

   // Row pointer walks all rows in turn
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         row_reg <= '0;
      end else if (refresh_start) begin
         row_reg <= (row_reg == ROW_W'(ROWS - 1)) ? '0 : row_reg + 1'b1;
      end
   end

   // Refresh owed or running, passed to the link
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         refresh_need_reg <= 1'b0;
      end else begin
         refresh_need_reg <= pending_reg || (busy_cnt_reg != 8'h00);
      end
   end

   assign refresh_row = row_reg;

   // -----------------------------------------------------------------
   // Link domain: synchronisers of quasi-static core state
   // -----------------------------------------------------------------
   logic      need_s1_reg;
   logic      need_s2_reg;
   logic      fixed_s1_reg;
   logic      fixed_s2_reg;
   logic      awake_link_reg;
   srb_word_t main_s1_reg;
   srb_word_t main_s2_reg;
   srb_word_t rcfg_s1_reg;
   srb_word_t rcfg_s2_reg;

   // Two flops each; only settle once the frame clock runs
   always_ff @(posedge link_clk) begin
      need_s1_reg  <= refresh_need_reg;
      need_s2_reg  <= need_s1_reg;
      fixed_s1_reg <= fixed_reg;
      fixed_s2_reg <= fixed_s1_reg;
      main_s1_reg  <= main_word;
      main_s2_reg  <= main_s1_reg;
      rcfg_s1_reg  <= rcfg_word;
      rcfg_s2_reg  <= rcfg_s1_reg;
   end

   // -----------------------------------------------------------------
   // Link domain: phase sequencer
   // -----------------------------------------------------------------
   srb_link_state_t state_reg;
   logic [4:0]      cnt_reg;
   logic [47:0]     ca_reg;
   logic [47:0]     ca_next;
   logic            ca_last;
   logic            long_now;
   logic            is_read_reg;
   logic            is_regsp_reg;
   logic            regsel_reg;
   logic [ADDR_W-1:0] addr_reg;
   srb_byte_t       rd_byte;
   srb_word_t       reg_rd_word;
   srb_byte_t       mem [DEPTH];

   assign ca_next  = {ca_reg[39:0], byte_lines_in};
   assign ca_last  = (cnt_reg == 5'(`SRB_CA_EDGES - 1));
   assign long_now = need_s2_reg || fixed_s2_reg;

   // Phase, counters and address; select high ends the frame at once
   always_ff @(posedge link_clk or posedge cs_n) begin
      if (cs_n) begin
         state_reg    <= LS_CA;
         cnt_reg      <= 5'h00;
         ca_reg       <= 48'h000000000000;
         is_read_reg  <= 1'b0;
         is_regsp_reg <= 1'b0;
         regsel_reg   <= 1'b0;
         addr_reg     <= '0;
      end else begin
         case (state_reg)
            LS_CA: begin
               ca_reg  <= ca_next;
               cnt_reg <= cnt_reg + 5'h01;
               if (ca_last) begin
                  is_read_reg  <= ca_next[`SRB_CA_READ_BIT];
                  is_regsp_reg <= ca_next[`SRB_CA_REGSP_BIT];
                  regsel_reg   <= ca_next[`SRB_CA_REGSEL_BIT];
                  addr_reg     <= ca_next[`SRB_CA_REGSP_BIT] ? '0 : ca_next[ADDR_W-1:0];
                  if (!awake_link_reg) begin
                     state_reg <= LS_IGNORE;
                  end else if (!ca_next[`SRB_CA_READ_BIT] && ca_next[`SRB_CA_REGSP_BIT]) begin
                     state_reg <= LS_DATA;
                  end else begin
                     state_reg <= LS_LAT;
                     cnt_reg   <= long_now ? 5'(2 * LATENCY_EDGES - 1) : 5'(LATENCY_EDGES - 1);
                  end
               end
            end
            LS_LAT: begin
               if (cnt_reg == 5'h00) begin
                  state_reg <= LS_DATA;
                  if (is_read_reg) begin
                     addr_reg <= addr_reg + 1'b1;
                  end
               end else begin
                  cnt_reg <= cnt_reg - 5'h01;
               end
            end
            LS_DATA: begin
               addr_reg <= addr_reg + 1'b1;
            end
            default: begin
               cnt_reg <= cnt_reg;
            end
         endcase
      end
   end

   // Byte to send: register word high byte first, else array
   assign reg_rd_word = (regsel_reg == `SRB_REG_REFRESH_CONFIG) ? rcfg_s2_reg : main_s2_reg;
   assign rd_byte     = is_regsp_reg ? (addr_reg[0] ? reg_rd_word[7:0] : reg_rd_word[15:8])
                                     : mem[addr_reg];

   // Pin drivers; released whenever the frame is closed
   always_ff @(posedge link_clk or posedge cs_n) begin
      if (cs_n) begin
         byte_lines_out        <= 8'h00;
         byte_lines_oe         <= 1'b0;
         read_write_strobe_out <= 1'b0;
         read_write_strobe_oe  <= 1'b0;
      end else begin
         case (state_reg)
            LS_CA: begin
               byte_lines_oe <= 1'b0;
               // Latency flag driven in command-address, then turnaround on writes; reads keep strobe driven low
               read_write_strobe_oe  <= awake_link_reg && (!ca_last || ca_next[`SRB_CA_READ_BIT]);
               read_write_strobe_out <= awake_link_reg && !ca_last && long_now;
            end
            LS_LAT: begin
               if (is_read_reg && cnt_reg == 5'h00) begin
                  byte_lines_oe         <= 1'b1;
                  byte_lines_out        <= rd_byte;
                  read_write_strobe_out <= 1'b1;
               end
            end
            LS_DATA: begin
               if (is_read_reg) begin
                  byte_lines_out        <= rd_byte;
                  read_write_strobe_out <= ~read_write_strobe_out;
               end
            end
            default: begin
               byte_lines_oe        <= 1'b0;
               read_write_strobe_oe <= 1'b0;
            end
         endcase
      end
   end

   // Array writes; strobe high masks the byte in latency writes
   always_ff @(posedge link_clk) begin
      if (state_reg == LS_DATA && !is_read_reg && !is_regsp_reg && !read_write_strobe_in) begin
         mem[addr_reg] <= byte_lines_in;
      end
   end

   // Register write capture, handed over by toggle; link copy of awake bit
   always_ff @(posedge link_clk or posedge srst) begin
      if (srst) begin
         reg_hi_reg     <= 8'h00;
         reg_wdata_reg  <= 16'h0000;
         reg_wsel_reg   <= 1'b0;
         reg_wtgl_reg   <= 1'b0;
         awake_link_reg <= 1'b1;
      end else if (state_reg == LS_DATA && !is_read_reg && is_regsp_reg) begin
         if (!addr_reg[0]) begin
            reg_hi_reg <= byte_lines_in;
         end else begin
            reg_wdata_reg <= {reg_hi_reg, byte_lines_in};
            reg_wsel_reg  <= regsel_reg;
            reg_wtgl_reg  <= ~reg_wtgl_reg;
            if (regsel_reg == `SRB_REG_MAIN_CONFIG) begin
               awake_link_reg <= reg_hi_reg[`SRB_MAIN_AWAKE_BIT - 8];
            end
         end
      end else if (state_reg == LS_CA && ca_last && !awake_link_reg) begin
         awake_link_reg <= 1'b1;                                      // Dummy frame wakes the link
      end
   end
endmodule

// [testbench/srb_device_chk.sv]
// Concurrent checks on the link pins and refresh row of srb_device.
// Assumes link_clk runs only while cs_n is low.
`timescale 1ns/1ns
module srb_device_chk #(
   parameter int ROWS          = 8192,
   parameter int LATENCY_EDGES = 12
) (
   input logic                    ref_clk,
   input logic                    srst,
   input logic                    link_clk,
   input logic                    cs_n,
   input logic                    byte_lines_oe,
   input logic                    read_write_strobe_out,
   input logic                    read_write_strobe_oe,
   input logic [$clog2(ROWS)-1:0] refresh_row
);
   // ----------------------------------------
   // Link edge counter and assertions
   // ----------------------------------------
   logic [5:0] ecnt;

   // Rising link edges seen in this frame
   always_ff @(posedge link_clk or posedge cs_n) begin
      if (cs_n) begin
         ecnt <= 6'h00;
      end else if (ecnt != 6'h3F) begin
         ecnt <= ecnt + 6'h01;
      end
   end

   row_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
      !cs_n [*6] |-> $stable(refresh_row)) else $error("refresh row moved during a frame");
   pins_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
      cs_n |-> !byte_lines_oe && !read_write_strobe_oe) else $error("pins driven while deselected");
   ca_drive_a: assert property (@(posedge link_clk) disable iff (srst)
      $rose(read_write_strobe_oe) |-> ecnt == 6'h01) else $error("strobe drive began late");
   turn_a: assert property (@(posedge link_clk) disable iff (srst)
      $fell(read_write_strobe_oe) |-> ecnt == 6'h06 || ecnt == 6'h00) else $error("strobe released off turnaround");
   lat_len_a: assert property (@(posedge link_clk) disable iff (srst)
      $rose(byte_lines_oe) |-> ecnt == 6'(6 + LATENCY_EDGES) || ecnt == 6'(6 + 2 * LATENCY_EDGES))
      else $error("read data at wrong latency");
   lat_low_a: assert property (@(posedge link_clk) disable iff (srst)
      $rose(byte_lines_oe) |-> $past(read_write_strobe_oe) && !$past(read_write_strobe_out) && read_write_strobe_out)
      else $error("strobe not low in read latency");
   toggle_a: assert property (@(posedge link_clk) disable iff (srst)
      byte_lines_oe && $past(byte_lines_oe) |-> read_write_strobe_out != $past(read_write_strobe_out))
      else $error("read strobe did not toggle");
   both_a: assert property (@(posedge link_clk) disable iff (srst)
      byte_lines_oe |-> read_write_strobe_oe && ecnt > 6'h06) else $error("data driven without strobe");

   // Main scenarios reached
   cover property (@(posedge link_clk) $rose(byte_lines_oe) && ecnt == 6'(6 + 2 * LATENCY_EDGES));
   cover property (@(posedge link_clk) $rose(byte_lines_oe) && ecnt == 6'(6 + LATENCY_EDGES));
   cover property (@(posedge link_clk) $fell(read_write_strobe_oe) && ecnt == 6'h06);
endmodule

bind srb_device srb_device_chk #(.ROWS(ROWS), .LATENCY_EDGES(LATENCY_EDGES)) chk (
   .ref_clk(ref_clk), .srst(srst), .link_clk(link_clk), .cs_n(cs_n), .byte_lines_oe(byte_lines_oe),
   .read_write_strobe_out(read_write_strobe_out), .read_write_strobe_oe(read_write_strobe_oe),
   .refresh_row(refresh_row));

// [testbench/srb_host_model.sv]
// Host memory controller model: runs frames on the link, one byte per rise.
// Assumes srb_pkg is compiled first; link clock stands low between frames.
`timescale 1ns/1ns
module srb_host_model #(
   parameter int LAT = 12
) (
   output logic               link_clk,
   output logic               cs_n,
   output srb_pkg::srb_byte_t byte_lines_in,
   output logic               read_write_strobe_in,
   input  srb_pkg::srb_byte_t byte_lines_out,
   input  logic               byte_lines_oe,
   input  logic               read_write_strobe_out,
   input  logic               read_write_strobe_oe
);
   import srb_pkg::*;
   srb_byte_t dq, last_dq, rd [0:7];
   logic      dq_oe, stb, stb_oe, last_stb, ca_stb;
   int        nrd, first_e;

   // Wire level: the driver, else inverse of the last level
   assign byte_lines_in = byte_lines_oe ? byte_lines_out : (dq_oe ? dq : ~last_dq);
   assign read_write_strobe_in = read_write_strobe_oe ? read_write_strobe_out : (stb_oe ? stb : ~last_stb);

   always @(posedge link_clk) begin
      last_dq <= byte_lines_in;
      last_stb <= read_write_strobe_in;
   end

   initial begin
      link_clk = 1'b0;
      cs_n = 1'b1;
      {dq, dq_oe, stb, stb_oe, last_dq, last_stb} = '0;
   end

   // ----------------------------------------
   // One frame: command-address, latency, data
   // ----------------------------------------
   task automatic frame(input logic [47:0] ca, input int nw, input srb_byte_t w0, input srb_byte_t w1,
                        input logic m1, input int nr);
      int e, idx, lat;
      nrd = 0;
      first_e = -1;
      ca_stb = 1'b0;
      lat = LAT;
      cs_n = 1'b0;
      #37;
      for (e = 0; e < 40; e++) begin
         idx = e - (ca[46] ? 6 : 6 + lat);
         dq_oe = (e < 6) || (idx >= 0 && idx < nw);
         dq = (e < 6) ? ca[47 - 8 * e -: 8] : (idx == 0 ? w0 : w1);
         stb_oe = !ca[46] && idx >= 0 && idx < nw;
         stb = (idx == 1) && m1;
         #40 link_clk = 1'b1;
         #40 link_clk = 1'b0;
         if (e == 4) ca_stb = read_write_strobe_out;
         lat = ca_stb ? 2 * LAT : LAT;
         if (byte_lines_oe && nrd < 8) begin
            if (first_e < 0) first_e = e;
            rd[nrd] = byte_lines_out;
            nrd++;
         end
         if ((nr > 0 && nrd >= nr) || (nw > 0 && idx >= nw - 1)) break;
      end
      dq_oe = 1'b0;
      stb_oe = 1'b0;
      #7 cs_n = 1'b1;
      #60;
   endtask
endmodule

// [testbench/self_refresh_bus_states_test.sv]
// Self-checking bench for srb_device with a host model on the link.
// Assumes srb_pkg, the design, checker and host model are compiled first.
`timescale 1ns/1ns
module self_refresh_bus_states_test;
   import srb_pkg::*;
   localparam int BASE = 1000;
   logic        ref_clk, srst, link_clk, cs_n, stb_in, stb_out, stb_oe, dq_oe;
   srb_byte_t   dq_in, dq_out;
   logic [12:0] row;
   int          errors, checked;

   srb_device #(.BASE_CYC(BASE)) uut (.ref_clk(ref_clk), .srst(srst), .link_clk(link_clk), .cs_n(cs_n),
      .byte_lines_in(dq_in), .byte_lines_out(dq_out), .byte_lines_oe(dq_oe), .read_write_strobe_in(stb_in),
      .read_write_strobe_out(stb_out), .read_write_strobe_oe(stb_oe), .refresh_row(row));
   srb_host_model host (.link_clk(link_clk), .cs_n(cs_n), .byte_lines_in(dq_in), .read_write_strobe_in(stb_in),
      .byte_lines_out(dq_out), .byte_lines_oe(dq_oe), .read_write_strobe_out(stb_out), .read_write_strobe_oe(stb_oe));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   function automatic logic [47:0] ca(input logic rd, input logic regsp, input logic [9:0] a);
      return {rd, regsp, 36'h0, a};
   endfunction

   task automatic rreg(input logic sel, output logic [15:0] v);
      host.frame(ca(1'b1, 1'b1, {9'h000, sel}), 0, 8'h00, 8'h00, 1'b0, 2);
      v = {host.rd[0], host.rd[1]};
   endtask

   task automatic wreg(input logic sel, input logic [15:0] v);
      host.frame(ca(1'b0, 1'b1, {9'h000, sel}), 2, v[15:8], v[7:0], 1'b0, 0);
   endtask

   // Cycles until refresh_row next moves
   task automatic wait_row(output int n);
      logic [12:0] r;
      r = row;
      n = 0;
      while (row === r && n < 5000) begin
         @(negedge ref_clk);
         n++;
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      check({dq_oe, stb_oe, row}, 32'h0);
   endtask

   task automatic t_defaults;
      logic [15:0] v;
      rreg(1'b1, v);
      check(v, 16'h0002);
      check(host.first_e, 5 + 24);
      rreg(1'b0, v);
      check(v, 16'h8008);
   endtask

   task automatic t_variable;
      logic [15:0] v;
      int n;
      wreg(1'b0, 16'h8000);
      wait_row(n);
      repeat (20) @(negedge ref_clk);
      rreg(1'b0, v);
      check(v, 16'h8000);
      check(host.ca_stb, 1'b0);
      check(host.first_e, 5 + 12);
   endtask

   task automatic t_collide;
      logic [12:0] r;
      int n;
      wait_row(n);
      repeat (BASE - 15) @(negedge ref_clk);
      r = row;
      fork
         host.frame(ca(1'b1, 1'b0, 10'h010), 0, 8'h00, 8'h00, 1'b0, 2);
         begin
            repeat (200) @(negedge ref_clk);
            check(row, r);
         end
      join
      check(host.ca_stb, 1'b1);
      check(host.first_e, 5 + 24);
      repeat (20) @(negedge ref_clk);
      check(row, r + 13'h0001);
   endtask

   task automatic t_memory;
      host.frame(ca(1'b0, 1'b0, 10'h010), 2, 8'h5A, 8'hC3, 1'b0, 0);
      host.frame(ca(1'b0, 1'b0, 10'h010), 2, 8'h11, 8'h22, 1'b1, 0);
      host.frame(ca(1'b1, 1'b0, 10'h010), 0, 8'h00, 8'h00, 1'b0, 2);
      check({host.rd[0], host.rd[1]}, 16'h11C3);
   endtask

   task automatic t_intervals;
      logic [1:0] code [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
      int per [4] = '{2 * BASE, 4 * BASE, 3 * BASE / 2, BASE};
      logic [15:0] v;
      int n;
      for (int i = 0; i < 4; i++) begin
         wreg(1'b1, {14'h0000, code[i]});
         rreg(1'b1, v);
         check(v, {14'h0000, code[i]});
         wait_row(n);
         wait_row(n);
         check(n > per[i] - 3 && n < per[i] + 3, 1'b1);
      end
   endtask

   task automatic t_sleep;
      logic [15:0] v;
      wreg(1'b0, 16'h0008);
      repeat (20) @(negedge ref_clk);
      rreg(1'b1, v);
      check(host.nrd, 0);
      rreg(1'b1, v);
      check(v, 16'h0002);
   endtask

   // Watchdog against a hung run
   initial begin
      #900000;
      errors++;
      results;
   end

   initial begin
      srst = 1'b1;
      errors = 0;
      checked = 0;
      repeat (6) @(negedge ref_clk);
      t_reset;
      repeat (6) @(negedge ref_clk);
      srst = 1'b0;
      repeat (4) @(negedge ref_clk);
      t_defaults;
      t_variable;
      t_collide;
      t_memory;
      t_intervals;
      t_sleep;
      results;
   end
endmodule
